// ---- inc/sram_ctrl_pkg.sv ----
// constants shared by the 1k-by-1 static ram controller
package sram_ctrl_pkg;
  localparam int unsigned ADDR_W = 10; // word address width
  localparam int unsigned WORDS = 1024; // words per part
  localparam int unsigned CLK_PERIOD_PS = 50000; // 20 mhz reference
  localparam int unsigned STROBE_MIN_PS = 7000; // least strobe low time
  localparam int unsigned SETUP_MIN_PS = 1000; // address/data setup before strobe
  localparam int unsigned HOLD_MIN_PS = 2000; // hold after strobe
  localparam int unsigned ACCESS_MAX_PS = 10000; // address access time
  // least times round up, none below one cycle
  localparam int unsigned STROBE_CYC_RAW = (STROBE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETUP_CYC_RAW = (SETUP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HOLD_CYC_RAW = (HOLD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACCESS_CYC_RAW = (ACCESS_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] STROBE_CYC = 2'(STROBE_CYC_RAW < 1 ? 1 : STROBE_CYC_RAW);
  localparam logic [1:0] SETUP_CYC = 2'(SETUP_CYC_RAW < 1 ? 1 : SETUP_CYC_RAW);
  localparam logic [1:0] HOLD_CYC = 2'(HOLD_CYC_RAW < 1 ? 1 : HOLD_CYC_RAW);
  localparam logic [1:0] ACCESS_CYC = 2'(ACCESS_CYC_RAW < 1 ? 1 : ACCESS_CYC_RAW);
  localparam logic [1:0] CNT_ONE = 2'h1; // counter step
  localparam logic [1:0] CNT_ZERO = 2'h0; // counter rest
  localparam logic [1:0] CNT_FULL = 2'h3; // counter ceiling for the strobe width checker
  localparam logic [1:0] SYNC_CYC = 2'h2; // synchroniser stages on the data pins
  localparam logic [1:0] SEL_NONE_N = 2'h3; // both parts deselected
  localparam logic [1:0] SEL_PART0_N = 2'h2; // lower part selected, address bit 10 clear
  localparam logic [1:0] SEL_PART1_N = 2'h1; // upper part selected, address bit 10 set
  // controller states, gray along idle-setup-strobe-hold and idle-access
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h2,
    ST_ACCESS = 3'h4
  } ctrl_state_e;
endpackage

// ---- hdl/sram_ctrl.sv ----
// controller that drives two 1k-by-1 static rams through their pins
`timescale 1ns/100ps
module sram_ctrl (
  input wire logic ref_clk_i, // 20 mhz clock
  input wire logic reset_i, // async reset, active high
  input wire logic req_i, // request pulse or level, taken when idle
  input wire logic req_write_i, // 1 write, 0 read
  input wire logic [10:0] req_addr_i, // bit 10 picks one of two parts
  input wire logic req_data_i, // bit to write
  input wire logic [1:0] read_bit_out_i, // data outputs of the two parts
  output logic busy_o, // access in progress
  output logic done_o, // one-cycle end of access
  output logic rd_data_o, // read result, valid with done
  output logic [9:0] bit_address_o, // address to both parts
  output logic [1:0] chip_select_n_o, // per-part select, active low
  output logic write_strobe_n_o, // write strobe, active low
  output logic write_bit_in_o // data to both parts
);
  sram_ctrl_pkg::ctrl_state_e state, next_state;
  logic [1:0] cnt; // time in current phase
  logic [1:0] next_cnt;
  logic req_write; // latched direction
  logic [1:0] rd_sync1, rd_sync2; // data pins synchronised
  logic [1:0] sel_n_dec; // decoded selects for a new request
  logic cnt_hit_setup; // setup phase has run its length
  logic cnt_hit_strobe; // strobe phase has run its length
  logic cnt_hit_hold; // hold phase has run its length
  logic cnt_hit_access; // read wait, access plus synchroniser, is over
  logic rd_pick; // wired-or of both parts
  logic [1:0] strobe_low_cnt; // checker helper, cycles with the strobe low

  // one phase-end test shared by every timed phase of an access
  function automatic logic phase_end(input logic [1:0] count, input logic [1:0] len);
    phase_end = (count == len);
  endfunction

  // bit 10 of the request chooses one part, no external decoder
  assign sel_n_dec = req_addr_i[10] ? sram_ctrl_pkg::SEL_PART1_N
    : sram_ctrl_pkg::SEL_PART0_N;
  // deselected part drives low, so an or of both gives the read bit
  assign rd_pick = |rd_sync2;
  assign cnt_hit_setup = phase_end(cnt, sram_ctrl_pkg::SETUP_CYC);
  assign cnt_hit_strobe = phase_end(cnt, sram_ctrl_pkg::STROBE_CYC);
  assign cnt_hit_hold = phase_end(cnt, sram_ctrl_pkg::HOLD_CYC);
  // two synchroniser stages plus the access time cover the async read path
  assign cnt_hit_access = phase_end(cnt,
    sram_ctrl_pkg::ACCESS_CYC + sram_ctrl_pkg::SYNC_CYC);

  // next state and phase counter
  always_comb begin
    next_state = state;
    next_cnt = cnt + sram_ctrl_pkg::CNT_ONE;
    case (state)
      sram_ctrl_pkg::ST_IDLE: begin
        next_cnt = sram_ctrl_pkg::CNT_ZERO;
        if (req_i) begin
          next_state = req_i && req_write_i ? sram_ctrl_pkg::ST_SETUP : sram_ctrl_pkg::ST_ACCESS;
        end
      end
      sram_ctrl_pkg::ST_SETUP: begin
        if (cnt_hit_setup) begin
          next_state = sram_ctrl_pkg::ST_STROBE;
          next_cnt = sram_ctrl_pkg::CNT_ONE;
        end
      end
      sram_ctrl_pkg::ST_STROBE: begin
        if (cnt_hit_strobe) begin
          next_state = sram_ctrl_pkg::ST_HOLD;
          next_cnt = sram_ctrl_pkg::CNT_ONE;
        end
      end
      sram_ctrl_pkg::ST_HOLD: begin
        if (cnt_hit_hold) begin
          next_state = sram_ctrl_pkg::ST_IDLE;
        end
      end
      sram_ctrl_pkg::ST_ACCESS: begin
        // wait for access time plus two synchroniser stages
        if (cnt_hit_access) begin
          next_state = sram_ctrl_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sram_ctrl_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= sram_ctrl_pkg::ST_IDLE;
      cnt <= sram_ctrl_pkg::CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // two-flop synchroniser for the ram data pins
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_sync1 <= 2'h0;
      rd_sync2 <= 2'h0;
    end else begin
      rd_sync1 <= read_bit_out_i;
      rd_sync2 <= rd_sync1;
    end
  end

  // pin drivers: address, data, select latched at request and held
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_address_o <= 10'h000;
      write_bit_in_o <= 1'h0;
      chip_select_n_o <= sram_ctrl_pkg::SEL_NONE_N; // both parts idle, outputs low
      req_write <= 1'h0;
    end else if (state == sram_ctrl_pkg::ST_IDLE && req_i) begin
      bit_address_o <= req_addr_i[9:0];
      write_bit_in_o <= req_data_i;
      chip_select_n_o <= sel_n_dec;
      req_write <= req_write_i;
    end else if (next_state == sram_ctrl_pkg::ST_IDLE) begin
      // deselect ends the access, so nothing stores after hold
      chip_select_n_o <= sram_ctrl_pkg::SEL_NONE_N;
    end
  end

  // write strobe low only in the strobe phase, data already stable
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      write_strobe_n_o <= 1'h1;
    end else begin
      write_strobe_n_o <= (next_state != sram_ctrl_pkg::ST_STROBE);
    end
  end

  // status and read result
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_o <= 1'h0;
      done_o <= 1'h0;
      rd_data_o <= 1'h0;
    end else begin
      busy_o <= (next_state != sram_ctrl_pkg::ST_IDLE);
      done_o <= (state != sram_ctrl_pkg::ST_IDLE) && (next_state == sram_ctrl_pkg::ST_IDLE);
      if (state == sram_ctrl_pkg::ST_ACCESS && next_state == sram_ctrl_pkg::ST_IDLE) begin
        rd_data_o <= rd_pick;
      end
    end
  end

  // checker helper: cycles the strobe has stood low, saturating at the ceiling
  // it only feeds the width assertion, so saturation never changes behaviour
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      strobe_low_cnt <= sram_ctrl_pkg::CNT_ZERO;
    end else if (write_strobe_n_o) begin
      // strobe high, start afresh at the next fall
      strobe_low_cnt <= sram_ctrl_pkg::CNT_ZERO;
    end else if (strobe_low_cnt != sram_ctrl_pkg::CNT_FULL) begin
      strobe_low_cnt <= strobe_low_cnt + sram_ctrl_pkg::CNT_ONE;
    end
  end

  // the checks below sample on the controller clock and sleep during reset

  // strobe never low while both parts are deselected
  a_strobe_needs_sel: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !write_strobe_n_o |-> (chip_select_n_o != sram_ctrl_pkg::SEL_NONE_N))
    else $error("strobe without select");

  // strobe stood low at least the counted cycles before it rose
  a_strobe_width: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(write_strobe_n_o) |-> (strobe_low_cnt >= sram_ctrl_pkg::STROBE_CYC))
    else $error("strobe too short");

  // address and data do not move while the strobe is low
  a_data_stable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !write_strobe_n_o |-> $stable(write_bit_in_o) && $stable(bit_address_o))
    else $error("write data moved");

  // select, address and data still stand in the cycle after the strobe rises
  a_hold_after: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(write_strobe_n_o) |-> (chip_select_n_o != sram_ctrl_pkg::SEL_NONE_N)
      && $stable(bit_address_o) && $stable(write_bit_in_o))
    else $error("write hold too short");

  // only one part is selected at a time
  a_one_select: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    chip_select_n_o != 2'h0)
    else $error("both parts selected");

  // no strobe while a read waits for its data
  a_read_no_strobe: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state == sram_ctrl_pkg::ST_ACCESS) |-> write_strobe_n_o)
    else $error("strobe in read");

  // every access ends within a bound
  a_access_ends: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(busy_o) |-> ##[1:8] done_o)
    else $error("access hung");

  // done is a single-cycle pulse
  a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    done_o |=> !done_o)
    else $error("done held too long");

  // address follows the request that was taken
  a_addr_taken: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state == sram_ctrl_pkg::ST_IDLE) && req_i |=> bit_address_o == $past(req_addr_i[9:0]))
    else $error("address not taken");

  // parts stay deselected while no access runs
  a_idle_desel: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !busy_o && !done_o |-> (chip_select_n_o == sram_ctrl_pkg::SEL_NONE_N))
    else $error("select left on");

  // main scenarios: a full write, a read returning one, each part in use
  c_write: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    $fell(write_strobe_n_o) ##[1:8] done_o);
  c_read_hi: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    done_o && !req_write && (chip_select_n_o == sram_ctrl_pkg::SEL_NONE_N) && rd_data_o);
  c_upper_part: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    chip_select_n_o == sram_ctrl_pkg::SEL_PART1_N);
  c_lower_part: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    chip_select_n_o == sram_ctrl_pkg::SEL_PART0_N);
endmodule

// ---- testbench/sram_1k_model.sv ----
// behavioural 1k-by-1 static ram standing at the controller's far side
`timescale 1ns/100ps
module sram_1k_model (
  input wire logic [9:0] bit_address_i, // word address
  input wire logic chip_select_n_i, // select, active low
  input wire logic write_strobe_n_i, // write strobe, active low
  input wire logic write_bit_in_i, // bit to store
  output logic read_bit_out_o // stored bit, low when idle
);
  logic mem [0:1023]; // 1024 single-bit words
  // cleared so that an unwritten word reads as a known value
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 1'b0;
    end
  end
  // level-sensitive store, no clock anywhere
  always @* begin
    if (!chip_select_n_i && !write_strobe_n_i) begin
      mem[bit_address_i] = write_bit_in_i;
    end
  end
  // low while deselected or writing, so outputs may be ORed
  assign read_bit_out_o = (chip_select_n_i || !write_strobe_n_i) ? 1'b0 : mem[bit_address_i];
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the 1k-by-1 static ram controller
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 1'b0, reset = 1'b1, req = 1'b0, req_write = 1'b0, req_data = 1'b0;
  logic [10:0] req_addr = 11'h000; // bit 10 picks the part
  logic [1:0] rd_bits, chip_select_n; // part outputs and selects
  logic [9:0] bit_address;
  logic busy, done, rd_data, write_strobe_n, write_bit_in;
  int fails = 0, n_tests = 0;
  int ref_mem [0:2047] = '{default: 0}; // reference of both parts
  logic [10:0] edges [4] = '{11'h000, 11'h3ff, 11'h400, 11'h7ff}; // boundary words
  always #25 ref_clk = ~ref_clk;
  sram_ctrl uut (.ref_clk_i(ref_clk), .reset_i(reset), .req_i(req), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_data_i(req_data), .read_bit_out_i(rd_bits), .busy_o(busy),
    .done_o(done), .rd_data_o(rd_data), .bit_address_o(bit_address),
    .chip_select_n_o(chip_select_n), .write_strobe_n_o(write_strobe_n),
    .write_bit_in_o(write_bit_in));
  sram_1k_model part0 (.bit_address_i(bit_address), .chip_select_n_i(chip_select_n[0]),
    .write_strobe_n_i(write_strobe_n), .write_bit_in_i(write_bit_in),
    .read_bit_out_o(rd_bits[0]));
  sram_1k_model part1 (.bit_address_i(bit_address), .chip_select_n_i(chip_select_n[1]),
    .write_strobe_n_i(write_strobe_n), .write_bit_in_i(write_bit_in),
    .read_bit_out_o(rd_bits[1]));
  // one compare, four-state exact
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one access: request held for one taking edge, then bounded wait for done
  task automatic access(input logic w, input logic [10:0] a, input logic d);
    int n;
    int lows;
    n = 0;
    lows = 0;
    @(posedge ref_clk) #2;
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_data = d;
    @(posedge ref_clk) #2;
    req = 1'b0;
    chk(busy, 1'b1);
    chk(chip_select_n, a[10] ? 2'b01 : 2'b10);
    chk(bit_address, a[9:0]);
    while (done !== 1'b1 && n < 20) begin
      @(posedge ref_clk) #2;
      n++;
      // data must not move while the strobe is low
      if (write_strobe_n === 1'b0) begin
        lows++;
        chk(write_bit_in, d);
      end
    end
    chk(done, 1'b1);
    chk(11'(lows), w ? 11'(sram_ctrl_pkg::STROBE_CYC) : 11'h000);
    chk(chip_select_n, 2'b11);
    if (w) ref_mem[a] = int'(d);
    else chk(rd_data, 11'(ref_mem[a]));
  endtask
  initial begin
    void'($urandom(32'h149f9ee6));
    repeat (8) @(posedge ref_clk);
    #2 reset = 1'b0;
    chk(chip_select_n, 2'b11);
    chk(write_strobe_n, 1'b1);
    chk(busy, 1'b0);
    chk(done, 1'b0);
    chk(rd_data, 1'b0);
    chk(bit_address, 10'h000);
    chk(write_bit_in, 1'b0);
    $display("test reset done");
    // boundary words of both parts, then overwrite and read back to back
    for (int i = 0; i < 4; i++) access(1'b1, edges[i], 1'b1);
    for (int i = 0; i < 4; i++) access(1'b0, edges[i], 1'b0);
    for (int i = 0; i < 4; i++) access(1'b1, edges[i], 1'b0);
    for (int i = 0; i < 4; i++) access(1'b0, edges[i], 1'b0);
    $display("test boundaries done");
    // random mix keeps the reference busy across both parts
    repeat (200) access(1'($urandom), 11'($urandom_range(2047, 0)), 1'($urandom));
    $display("test random done");
    tally_and_finish();
  end
  // watchdog well beyond the expected run of some 1300 cycles
  initial begin
    #1000000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
